// *** hw/sfr_space_pkg.sv ***
package sfr_space_pkg;

    // ----------------------------------------------------------------
    // bus and space geometry
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int SPACE_SIZE = 128;
    localparam logic [7:0] SPACE_BASE = 8'h80;

    // ----------------------------------------------------------------
    // register addresses used directly by the logic, except ADDR_PORT0_PINS and ADDR_PORT1_PINS, and ADDR_RESERVED_TOP, used only by a cover
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT0_PINS = 8'h80;
    localparam logic [7:0] ADDR_DATA_PTR_SELECT = 8'h86;
    localparam logic [7:0] ADDR_CLOCK_SPEED_CTRL = 8'h8E;
    localparam logic [7:0] ADDR_PORT1_PINS = 8'h90;
    localparam logic [7:0] ADDR_MEMORY_PAGE = 8'h92;
    localparam logic [7:0] ADDR_PORT0_DIRECTION = 8'h94;
    localparam logic [7:0] ADDR_PORT0_ALT_FUNC = 8'h95;
    localparam logic [7:0] ADDR_PORT1_DIRECTION = 8'h96;
    localparam logic [7:0] ADDR_PORT1_ALT_FUNC = 8'h97;
    localparam logic [7:0] ADDR_ADC_RESULT_HIGH = 8'hA2;
    localparam logic [7:0] ADDR_ADC_RESULT_LOW = 8'hA3;
    localparam logic [7:0] ADDR_RTC_WDOG_HIGH = 8'hAB;
    localparam logic [7:0] ADDR_RTC_WDOG_LOW = 8'hAC;
    localparam logic [7:0] ADDR_HARDWARE_REVISION = 8'hFE;
    localparam logic [7:0] ADDR_RESERVED_TOP = 8'hFF;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DPS_SEL_BIT = 0;
    localparam int CLOCK_SPEED_CTRL_MD_LSB = 0;
    localparam int CLOCK_SPEED_CTRL_MD_W = 3;
    localparam int PORT1_W = 3;

    // ----------------------------------------------------------------
    // per-address descriptor
    // ----------------------------------------------------------------
    typedef struct packed {
        logic present;
        logic readOnly;
        logic [7:0] resetVal;
        logic [7:0] fixMask;
        logic [7:0] fixVal;
    } sfr_info_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_req_t;

    // map of the space: presence, reset value, hard-wired bits
    function automatic sfr_info_t sfrInfo(input logic [7:0] a);
        sfr_info_t i;
        i = '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00};
        case (a)
            8'h80: i = '{1'b1, 1'b0, 8'hFF, 8'h00, 8'h00};
            8'h81: i = '{1'b1, 1'b0, 8'h07, 8'h00, 8'h00};
            8'h82, 8'h83, 8'h84, 8'h85: i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'h86: i = '{1'b1, 1'b0, 8'h00, 8'hFE, 8'h00};
            8'h87: i = '{1'b1, 1'b0, 8'h30, 8'h30, 8'h30};
            8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D:
                i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'h8E: i = '{1'b1, 1'b0, 8'h01, 8'h00, 8'h00};
            8'h8F: i = '{1'b1, 1'b0, 8'h00, 8'hFE, 8'h00};
            8'h90: i = '{1'b1, 1'b0, 8'hFF, 8'h00, 8'h00};
            8'h91: i = '{1'b1, 1'b0, 8'h08, 8'h0F, 8'h08};
            8'h92: i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'h94, 8'h96: i = '{1'b1, 1'b0, 8'hFF, 8'h00, 8'h00};
            8'h95, 8'h97, 8'h98, 8'h99: i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'hA0, 8'hA1: i = '{1'b1, 1'b0, 8'h80, 8'h00, 8'h00};
            8'hA2, 8'hA3: i = '{1'b1, 1'b1, 8'h00, 8'h00, 8'h00};
            8'hA4: i = '{1'b1, 1'b0, 8'h0A, 8'h00, 8'h00};
            8'hA8: i = '{1'b1, 1'b0, 8'h00, 8'h40, 8'h00};
            8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD:
                i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'hB1: i = '{1'b1, 1'b0, 8'h02, 8'h00, 8'h00};
            8'hB2, 8'hB3, 8'hB4, 8'hB6: i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'hB5: i = '{1'b1, 1'b0, 8'h1D, 8'h00, 8'h00};
            8'hB8: i = '{1'b1, 1'b0, 8'h80, 8'hC0, 8'h80};
            8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0, 8'hE0, 8'hF0:
                i = '{1'b1, 1'b0, 8'h00, 8'h00, 8'h00};
            8'hD8: i = '{1'b1, 1'b0, 8'h40, 8'h77, 8'h40};
            8'hE8, 8'hF8: i = '{1'b1, 1'b0, 8'hE0, 8'hE0, 8'hE0};
            8'hFE: i = '{1'b1, 1'b1, 8'h00, 8'h00, 8'h00};
            default: i = '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00};
        endcase
        return i;
    endfunction

endpackage

// *** hw/sfr_space_decode.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/1ns

module sfr_space_decode
    import sfr_space_pkg::*;
#(
    parameter logic [7:0] HW_REVISION = 8'h00 // arbitrary value
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wdogReset,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // status from peripherals
    input wire logic [7:0] adcResultHigh,
    input wire logic [7:0] adcResultLow,
    // controls to the core and peripherals
    output logic dpSelect,
    output logic [7:0] memPage,
    output logic [7:0] port0Dir,
    output logic [7:0] port0Alt,
    output logic [PORT1_W-1:0] port1Dir,
    output logic [PORT1_W-1:0] port1Alt,
    output logic [CLOCK_SPEED_CTRL_MD_W-1:0] stretchCycles,
    output logic [15:0] rtcWdogValue
);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    sfr_req_t req;
    sfr_info_t reqInfo;
    logic [6:0] reqIdx;
    logic reqWrOk;

    assign req = '{regAddr, regWdata, regWr, regRd};
    assign reqInfo = sfrInfo(req.addr);
    assign reqIdx = req.addr[6:0];
    // reserved and read-only addresses never take a write
    assign reqWrOk = req.wr && req.addr[7] && reqInfo.present && !reqInfo.readOnly;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] sfr_q [SPACE_SIZE];

    // one reset image for both reset sources
    function automatic logic [7:0] resetImage(input int idx);
        sfr_info_t ri;
        ri = sfrInfo(SPACE_BASE | 8'(idx));
        return (ri.present && !ri.readOnly) ? ri.resetVal : 8'h00;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int k = 0; k < SPACE_SIZE; k++)
            begin
                sfr_q[k] <= resetImage(k);
            end
        end
        else if (wdogReset)
        begin
            for (int k = 0; k < SPACE_SIZE; k++)
            begin
                sfr_q[k] <= resetImage(k);
            end
        end
        else if (reqWrOk)
        begin
            // all free bits stored, including unused ones
            sfr_q[reqIdx] <= (req.wdata & ~reqInfo.fixMask)
                | (reqInfo.fixVal & reqInfo.fixMask);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] readValue;

    always_comb
    begin
        readValue = 8'h00;
        if (req.addr[7] && reqInfo.present)
        begin
            case (req.addr)
                ADDR_ADC_RESULT_HIGH: readValue = adcResultHigh;
                ADDR_ADC_RESULT_LOW: readValue = adcResultLow;
                ADDR_HARDWARE_REVISION: readValue = HW_REVISION;
                default: readValue = sfr_q[reqIdx];
            endcase
            readValue = (readValue & ~reqInfo.fixMask)
                | (reqInfo.fixVal & reqInfo.fixMask);
        end
        else
        begin
            readValue = 8'h00;
        end
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdata <= 8'h00;
        end
        else if (req.rd)
        begin
            regRdata <= readValue;
        end
        else
        begin
            regRdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    logic [7:0] dpsReg;
    logic [7:0] ckconReg;
    logic [7:0] p1DirReg;
    logic [7:0] p1AltReg;

    assign dpsReg = sfr_q[ADDR_DATA_PTR_SELECT[6:0]];
    assign ckconReg = sfr_q[ADDR_CLOCK_SPEED_CTRL[6:0]];
    assign p1DirReg = sfr_q[ADDR_PORT1_DIRECTION[6:0]];
    assign p1AltReg = sfr_q[ADDR_PORT1_ALT_FUNC[6:0]];

    // pointer pair select
    assign dpSelect = dpsReg[DPS_SEL_BIT];

    // memory page
    assign memPage = sfr_q[ADDR_MEMORY_PAGE[6:0]];

    // port 0 direction and alternate function pair
    assign port0Dir = sfr_q[ADDR_PORT0_DIRECTION[6:0]];
    assign port0Alt = sfr_q[ADDR_PORT0_ALT_FUNC[6:0]];

    // port 1 has three pins; upper bits stored only
    assign port1Dir = p1DirReg[PORT1_W-1:0];
    assign port1Alt = p1AltReg[PORT1_W-1:0];

    // external access stretch
    assign stretchCycles = ckconReg[CLOCK_SPEED_CTRL_MD_LSB +: CLOCK_SPEED_CTRL_MD_W];

    // wakeup timer and watchdog word, high byte first
    assign rtcWdogValue = {sfr_q[ADDR_RTC_WDOG_HIGH[6:0]], sfr_q[ADDR_RTC_WDOG_LOW[6:0]]};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sfr_info_t pastInfo;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pastInfo <= '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00};
        end
        else
        begin
            pastInfo <= reqInfo;
        end
    end

    AST_FIXED_BITS: assert property (
        regRd && regAddr[7] |=> (regRdata & pastInfo.fixMask) == pastInfo.fixVal)
        else $error("hard-wired bits read wrong");

    AST_UNUSED_STORED: assert property (
        regWr && regAddr == ADDR_CLOCK_SPEED_CTRL && !wdogReset
        |=> ckconReg[7:6] == $past(regWdata[7:6]))
        else $error("unused bits not stored");

    AST_SAME_RESET: assert property (
        wdogReset |=> dpSelect == 1'b0 && memPage == 8'h00 && port0Dir == 8'hFF
            && port0Alt == 8'h00 && stretchCycles == 3'h1)
        else $error("watchdog reset image differs");

    AST_REVISION: assert property (
        regRd && regAddr == ADDR_HARDWARE_REVISION |=> regRdata == HW_REVISION)
        else $error("revision read wrong");

    AST_RTC_WORD: assert property (
        regWr && regAddr == ADDR_RTC_WDOG_HIGH && !wdogReset
        |=> rtcWdogValue[15:8] == $past(regWdata))
        else $error("rtc high byte not loaded");

    AST_PORT0_ALT: assert property (
        regWr && regAddr == ADDR_PORT0_ALT_FUNC && !wdogReset
        |=> port0Alt == $past(regWdata) && $stable(port0Dir))
        else $error("port 0 alternate function not loaded");

    AST_MEM_PAGE: assert property (
        regWr && regAddr == ADDR_MEMORY_PAGE && !wdogReset
        |=> memPage == $past(regWdata)
        ##1 ($past(regWr) || $past(wdogReset) || $stable(memPage)))
        else $error("memory page wrong");

    AST_DPS_SEL: assert property (
        regWr && regAddr == ADDR_DATA_PTR_SELECT && !wdogReset
        |=> dpSelect == $past(regWdata[0]))
        else $error("pointer select wrong");

    AST_RESERVED_READ: assert property (
        regRd && !(regAddr[7] && reqInfo.present) |=> regRdata == 8'h00)
        else $error("reserved read not zero");

    AST_RDATA_ONE_CYCLE: assert property (
        !regRd |=> regRdata == 8'h00)
        else $error("read data outside its cycle");

    COV_DPS_TOGGLE: cover property (
        regWr && regAddr == ADDR_DATA_PTR_SELECT ##1 dpSelect);
    COV_REV_READ: cover property (regRd && regAddr == ADDR_HARDWARE_REVISION);
    COV_RESERVED_READ: cover property (regRd && regAddr == ADDR_RESERVED_TOP);
    COV_WDOG_RESET: cover property (regWr ##1 wdogReset);

endmodule

// *** test/core_bus_model.sv ***
`timescale 1ns/1ns

module core_bus_model
(
    // clock
    input wire logic ref_clk,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [7:0] regRdata
);
    initial
    begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    // callers only write assigned addresses and never touch the top one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask
endmodule

// *** test/tb_sfr_space_decode.sv ***
`timescale 1ns/1ns

module tb_sfr_space_decode
    import sfr_space_pkg::*;
;
    localparam logic [7:0] HW_REV = 8'h5C; // arbitrary value

    logic ref_clk, rst_b, wdogReset, regWr, regRd, dpSelect;
    logic [7:0] regAddr, regWdata, regRdata, adcResultHigh, adcResultLow;
    logic [7:0] memPage, port0Dir, port0Alt;
    logic [2:0] port1Dir, port1Alt, stretchCycles;
    logic [15:0] rtcWdogValue;
    int mismatches = 0;
    int nChecks = 0;
    logic [15:0] rstTab [15] = '{16'h80FF, 16'h8107, 16'h8600, 16'h8730, 16'h8E01,
        16'h9108, 16'h9200, 16'h94FF, 16'hA080, 16'hA40A, 16'hB102, 16'hB51D,
        16'hB880, 16'hD840, 16'hE8E0};
    logic [23:0] fixTab [9] = '{24'h86FE_00, 24'h8730_30, 24'h8FFE_00, 24'h910F_08,
        24'hA840_00, 24'hB8C0_80, 24'hD877_40, 24'hE8E0_E0, 24'hF8E0_E0};

    core_bus_model core (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

    sfr_space_decode #(.HW_REVISION(HW_REV)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .wdogReset(wdogReset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .adcResultHigh(adcResultHigh),
        .adcResultLow(adcResultLow), .dpSelect(dpSelect), .memPage(memPage),
        .port0Dir(port0Dir), .port0Alt(port0Alt), .port1Dir(port1Dir),
        .port1Alt(port1Alt), .stretchCycles(stretchCycles), .rtcWdogValue(rtcWdogValue));

    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic resetImage();
        logic [7:0] d;
        for (int i = 0; i < 15; i++)
        begin
            core.rd(rstTab[i][15:8], d);
            chk(d, rstTab[i][7:0]);
        end
        chk({port0Dir, memPage}, 16'hFF00);
        chk({port1Dir, stretchCycles, dpSelect, rtcWdogValue[8:0]}, 16'hE400);
    endtask

    task automatic hardWired();
        logic [7:0] d, w;
        for (int p = 0; p < 2; p++)
        begin
            w = p ? 8'h00 : 8'hFF;
            for (int i = 0; i < 9; i++)
            begin
                core.wr(fixTab[i][23:16], w);
                core.rd(fixTab[i][23:16], d);
                chk(d, (w & ~fixTab[i][15:8]) | fixTab[i][7:0]);
            end
        end
    endtask

    task automatic pointerSelect();
        logic [7:0] d;
        core.wr(8'h86, 8'h01);
        chk(dpSelect, 1'b1);
        core.wr(8'h86, 8'hFE);
        core.rd(8'h86, d);
        chk({dpSelect, d}, 16'h0000);
    endtask

    task automatic portAndPage();
        logic [7:0] d;
        core.wr(8'h94, 8'hA5);
        core.wr(8'h95, 8'h3C);
        core.wr(8'h92, 8'h5A);
        core.wr(8'h96, 8'hF9);
        chk({port0Dir, port0Alt}, 16'hA53C);
        chk(memPage, 8'h5A);
        core.rd(8'h96, d);
        chk({d, 5'h00, port1Dir}, 16'hF901);
        core.wr(8'h97, 8'hFF);
        chk({13'h0000, port1Alt}, 16'h0007);
        core.wr(8'h8E, 8'hC6);
        core.rd(8'h8E, d);
        chk({d, 5'h00, stretchCycles}, 16'hC606);
    endtask

    task automatic rtcBytes();
        logic [7:0] d;
        core.wr(8'hAB, 8'h12);
        core.wr(8'hAC, 8'h34);
        chk(rtcWdogValue, 16'h1234);
        core.wr(8'hAC, 8'h56);
        core.rd(8'hAB, d);
        chk({d, rtcWdogValue[7:0]}, 16'h1256);
    endtask

    task automatic revAndHoles();
        logic [7:0] d;
        core.wr(8'hFE, 8'hFF);
        core.rd(8'hFE, d);
        chk(d, HW_REV);
        @(posedge ref_clk);
        #1;
        chk(regRdata, 8'h00);
        core.rd(8'hB0, d);
        chk(d, 8'h00);
        core.wr(8'hA2, 8'h00);
        core.rd(8'hA2, d);
        chk(d, 8'hC3);
        core.rd(8'hA3, d);
        chk(d, 8'h2A);
        core.rd(8'h7F, d);
        chk({d, port0Dir}, 16'h00A5);
    endtask

    task automatic watchdogReload();
        @(posedge ref_clk);
        wdogReset <= 1'b1;
        @(posedge ref_clk);
        wdogReset <= 1'b0;
        resetImage();
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        wdogReset = 1'b0;
        adcResultHigh = 8'hC3;
        adcResultLow = 8'h2A;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        resetImage();
        hardWired();
        pointerSelect();
        portAndPage();
        rtcBytes();
        revAndHoles();
        watchdogReload();
        summarize();
    end

    initial
    begin
        #50000;
        mismatches++;
        summarize();
    end
endmodule
